// file: logic/lpwk_ctrl.sv
`default_nettype none
module lpwk_ctrl
	import lpwk_pkg::*;
#(
	parameter int unsigned OBD_N = 4,
	parameter int unsigned SLEEP_CYC = ALERT_TO_SLEEP_CYC,
	parameter int unsigned RXW_CYC = RX_WAKE_CYC,
	parameter int unsigned DEB_CYC = IGN_DEBOUNCE_CYC,
	parameter int unsigned WSHORT_CYC = WAKE_SHORT_CYC,
	parameter int unsigned WLONG_CYC = WAKE_LONG_CYC
) (
	input wire logic clock, // 20 mhz system clock
	input wire logic rst, // async reset, high
	input wire logic [7:0] power_config_byte, // power configuration
	input wire logic ignition_monitor_input, // ignition / request pin
	input wire logic rx_pin, // uart receive pin
	input wire logic [OBD_N-1:0] obd_active, // obd inputs, high = active
	input wire logic processing, // core is working
	input wire logic ignition_level_query, // query strobe
	output logic ignition_level, // present pin level
	output logic alert_send, // pulse: send low power alert text
	output logic abort_obd, // pulse: abort obd, report stopped
	output logic low_power, // in sleep
	output logic outputs_off, // drive outputs recessive
	output logic volt_select, // bus voltage select
	output logic busy_pin, // busy output
	output logic protocol_close, // pulse: close protocol on wake
	output logic warm_reset // pulse: reset core, keep settings
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic ign_s1_q, ign_s2_q, rx_s1_q, rx_s2_q;
	logic [OBD_N-1:0] obd_s1_q, obd_s2_q;
	// pins are asynchronous, two flops each; rx and the request pin reset to their idle high [R13]
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ign_s1_q <= 1'b1;
			ign_s2_q <= 1'b1;
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			obd_s1_q <= '0;
			obd_s2_q <= '0;
		end else begin
			ign_s1_q <= ignition_monitor_input;
			ign_s2_q <= ign_s1_q;
			rx_s1_q <= rx_pin;
			rx_s2_q <= rx_s1_q;
			obd_s1_q <= obd_active;
			obd_s2_q <= obd_s1_q;
		end
	end
	// ------------------------------------------------------------
	// ignition debounce
	// ------------------------------------------------------------
	logic ign_level, ign_changed;
	lpwk_filter #(
		.STABLE_CYC(DEB_CYC), // [R20]
		.INIT(1'b1)
	) u_ign (
		.clock(clock),
		.rst(rst),
		.raw(ign_s2_q),
		.level(ign_level),
		.changed(ign_changed)
	);
	logic ign_fell, ign_rose;
	assign ign_fell = ign_changed && ign_level;
	assign ign_rose = ign_changed && !ign_level;
	// ------------------------------------------------------------
	// ignition level query
	// ------------------------------------------------------------
	logic ign_query_q;
	// read regardless of config bits [R2]
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ign_query_q <= 1'b1;
		end else if (ignition_level_query) begin
			ign_query_q <= ign_s2_q;
		end
	end
	assign ignition_level = ign_query_q;
	// ------------------------------------------------------------
	// request-to-send abort
	// ------------------------------------------------------------
	logic rts_prev_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rts_prev_q <= 1'b1;
		end else begin
			rts_prev_q <= ign_s2_q;
		end
	end
	// falling request while busy aborts and reports [R3]
	assign abort_obd = rts_prev_q && !ign_s2_q && processing && !low_power;
	// ------------------------------------------------------------
	// state machine
	// ------------------------------------------------------------
	localparam int unsigned TW = $clog2(WLONG_CYC + SLEEP_CYC + 1);
	lpwk_state_e state_q;
	logic [TW-1:0] tmr_q;
	// own width: a long receive count must not be cut to the sequence timer's width
	localparam int unsigned RW = $clog2(RXW_CYC + 1);
	logic [RW-1:0] rx_cnt_q;
	logic obd_armed_q, ign_seen_low_q, rx_wake;
	logic cfg_ign_sleep;
	assign cfg_ign_sleep = power_config_byte[CFG_MASTER_BIT] && power_config_byte[CFG_IGN_EN_BIT]; // [R19]
	// rx low counter; short glitches are ignored
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rx_cnt_q <= '0;
		end else if (state_q != LPWK_SLEEP || rx_s2_q) begin
			rx_cnt_q <= '0;
		end else if (rx_cnt_q != RW'(RXW_CYC)) begin
			rx_cnt_q <= rx_cnt_q + 1'b1;
		end
	end
	assign rx_wake = (rx_cnt_q == RW'(RXW_CYC)); // [R4]
	// obd wake armed once every input seen quiet in sleep
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			obd_armed_q <= 1'b0;
		end else if (state_q != LPWK_SLEEP) begin
			obd_armed_q <= 1'b0;
		end else if (obd_s2_q == '0) begin
			obd_armed_q <= 1'b1; // [R7]
		end
	end
	// ignition wake needs low then high, config bit 2 not needed
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ign_seen_low_q <= 1'b0;
		end else if (state_q != LPWK_SLEEP) begin
			ign_seen_low_q <= 1'b0;
		end else if (!ign_level) begin
			ign_seen_low_q <= 1'b1; // [R8]
		end
	end
	// main sequence
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q <= LPWK_RUN;
			tmr_q <= '0;
		end else begin
			case (state_q)
				LPWK_RUN: begin
					if (ign_fell && cfg_ign_sleep) begin
						state_q <= LPWK_ALERT; // [R1] [R19]
						tmr_q <= '0;
					end
				end
				LPWK_ALERT: begin
					if (tmr_q == TW'(SLEEP_CYC - 1)) begin
						state_q <= LPWK_SLEEP; // [R1]
						tmr_q <= '0;
					end else begin
						tmr_q <= tmr_q + 1'b1;
					end
				end
				LPWK_SLEEP: begin
					if (rx_wake || (obd_armed_q && obd_s2_q != '0)) begin
						state_q <= LPWK_WAKE; // [R4] [R6]
						tmr_q <= TW'(WSHORT_CYC - 1);
					end else if (ign_seen_low_q && ign_rose) begin
						state_q <= LPWK_WAKE; // [R8] [R9]
						tmr_q <= power_config_byte[CFG_WAKE_DLY_BIT] ? TW'(WLONG_CYC - 1) : TW'(WSHORT_CYC - 1);
					end
				end
				LPWK_WAKE: begin
					if (tmr_q == '0) begin
						state_q <= LPWK_RUN;
					end else begin
						tmr_q <= tmr_q - 1'b1;
					end
				end
				default: begin
					state_q <= LPWK_RUN;
					tmr_q <= '0;
				end
			endcase
		end
	end
	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	logic wake_done;
	assign wake_done = (state_q == LPWK_WAKE) && (tmr_q == '0);
	assign alert_send = (state_q == LPWK_RUN) && ign_fell && cfg_ign_sleep; // [R1]
	// settings live outside; warm reset keeps them, protocol only closed [R11] [R12]
	assign warm_reset = wake_done;
	assign protocol_close = wake_done;
	logic lp_q, busy_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lp_q <= 1'b0;
		end else begin
			lp_q <= (state_q == LPWK_SLEEP) || (state_q == LPWK_WAKE && tmr_q != '0);
		end
	end
	// busy follows processing, no self-raise; inverted in sleep [R14] [R16] [R18]
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b1;
		end else begin
			busy_q <= lp_q ? !processing : processing;
		end
	end
	assign low_power = lp_q;
	assign outputs_off = lp_q; // [R18]
	assign volt_select = 1'b0; // held low; select drive belongs to the protocol engine, low in sleep [R18]
	assign busy_pin = busy_q;
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	// helper: cycles spent in alert, counted apart from the sequence timer
	logic [TW-1:0] alert_age_q;
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			alert_age_q <= '0;
		end else if (state_q == LPWK_ALERT) begin
			alert_age_q <= alert_age_q + 1'b1;
		end else begin
			alert_age_q <= '0;
		end
	end
	a_alert_to_sleep: assert property (@(posedge clock) disable iff (rst) // [R1]
		state_q == LPWK_ALERT && alert_age_q == TW'(SLEEP_CYC - 1) |=> state_q == LPWK_SLEEP)
		else $error("sleep not entered after alert delay");
	a_alert_hold: assert property (@(posedge clock) disable iff (rst) // [R1]
		state_q == LPWK_ALERT && alert_age_q != TW'(SLEEP_CYC - 1) |=> state_q == LPWK_ALERT)
		else $error("alert left before its delay");
	a_alert_gated: assert property (@(posedge clock) disable iff (rst) // [R19]
		alert_send |-> cfg_ign_sleep)
		else $error("alert without enable bits");
	a_lp_outputs: assert property (@(posedge clock) disable iff (rst) // [R18]
		low_power |-> outputs_off && !volt_select)
		else $error("outputs not off in sleep");
	a_obd_unarmed: assert property (@(posedge clock) disable iff (rst) // [R7]
		state_q == LPWK_SLEEP && !obd_armed_q && !rx_wake && !ign_rose |=> state_q == LPWK_SLEEP)
		else $error("wake before obd quiet");
	a_rx_wake: assert property (@(posedge clock) disable iff (rst) // [R4]
		rx_wake && state_q == LPWK_SLEEP |=> state_q == LPWK_WAKE)
		else $error("rx pulse did not wake");
	a_abort_cause: assert property (@(posedge clock) disable iff (rst) // [R3]
		abort_obd |-> $past(ign_s2_q) && !ign_s2_q)
		else $error("abort without request fall");
	a_busy_follow: assert property (@(posedge clock) disable iff (rst) // [R14]
		!$past(rst) && !lp_q && !$past(lp_q) |-> busy_pin == $past(processing))
		else $error("busy does not follow processing");
	a_busy_sleep: assert property (@(posedge clock) disable iff (rst) // [R18]
		lp_q && $past(lp_q) |-> busy_pin == !$past(processing))
		else $error("busy not inverted in sleep");
	a_wake_close: assert property (@(posedge clock) disable iff (rst) // [R12]
		warm_reset |-> protocol_close ##1 (state_q == LPWK_RUN && !low_power))
		else $error("wake without protocol close");
endmodule : lpwk_ctrl
`default_nettype wire

// file: logic/lpwk_filter.sv
`default_nettype none
module lpwk_filter
	import lpwk_pkg::*;
#(
	parameter int unsigned STABLE_CYC = 4,
	parameter bit INIT = 1'b1
) (
	input wire logic clock, // system clock
	input wire logic rst, // async reset
	input wire logic raw, // synchronised level
	output logic level, // debounced level
	output logic changed // one-cycle pulse on change
);
	localparam int unsigned CW = $clog2(STABLE_CYC + 1);
	logic [CW-1:0] cnt_q;
	logic level_q;
	// ------------------------------------------------------------
	// stability counter
	// ------------------------------------------------------------
	// any level change counts, whatever drives the pin [R10]
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			level_q <= INIT;
		end else if (raw == level_q) begin
			cnt_q <= '0;
		end else if (cnt_q == CW'(STABLE_CYC - 1)) begin
			cnt_q <= '0;
			level_q <= raw;
		end else begin
			cnt_q <= cnt_q + 1'b1;
		end
	end
	assign level = level_q;
	assign changed = (raw != level_q) && (cnt_q == CW'(STABLE_CYC - 1));
endmodule : lpwk_filter
`default_nettype wire

// file: logic/lpwk_pkg.sv
// Notes on behaviour
// R1 - confirmed ignition low: alert, sleep 2 s later
// R2 - ignition query always shows present pin level
// R3 - request-to-send low aborts obd, reports stopped
// R4 - rx low at least 128 us wakes
// R5 - host sends slow space, at-sign or break
// R6 - obd active level in sleep starts wake
// R7 - obd wake armed only after all quiet
// R8 - ignition low then high wakes and resets
// R9 - ignition wake ignores bit 2; bit 1 delay
// R10 - any stable level change counts as ignition
// R11 - user settings survive wake unchanged
// R12 - protocol kept but closed; baud kept
// R13 - uart lines idle high, same baud
// R14 - busy high while processing, low when ready
// R15 - host samples busy, may pull request low
// R16 - after busy falls, wait for command indefinitely
// R17 - unused request-to-send held high
// R18 - sleep: outputs off, volt select low, busy inverted
// R19 - ignition sleep needs config b7 and b2
// R20 - debounce and wake delays are build constants
`default_nettype none
package lpwk_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned ALERT_TO_SLEEP_MS = 2000;
	localparam int unsigned ALERT_TO_SLEEP_CYC = CLK_HZ / 1000 * ALERT_TO_SLEEP_MS;
	localparam int unsigned RX_WAKE_US = 128;
	localparam int unsigned RX_WAKE_CYC = (CLK_HZ / 1_000_000) * RX_WAKE_US;
	localparam int unsigned IGN_DEBOUNCE_MS = 50;
	localparam int unsigned IGN_DEBOUNCE_CYC = CLK_HZ / 1000 * IGN_DEBOUNCE_MS;
	localparam int unsigned WAKE_SHORT_MS = 1000;
	localparam int unsigned WAKE_SHORT_CYC = CLK_HZ / 1000 * WAKE_SHORT_MS;
	localparam int unsigned WAKE_LONG_MS = 5000;
	localparam int unsigned WAKE_LONG_CYC = CLK_HZ / 1000 * WAKE_LONG_MS;
	// ------------------------------------------------------------
	// power_config_byte fields
	// ------------------------------------------------------------
	localparam int unsigned CFG_MASTER_BIT = 7;
	localparam int unsigned CFG_IGN_EN_BIT = 2;
	localparam int unsigned CFG_WAKE_DLY_BIT = 1;
	localparam logic [7:0] CFG_RESET = 8'h80;
	typedef enum {
		LPWK_RUN,
		LPWK_ALERT,
		LPWK_SLEEP,
		LPWK_WAKE
	} lpwk_state_e;
endpackage : lpwk_pkg
`default_nettype wire

// file: verif/low_power_wake_and_host_handshake_test.sv
`default_nettype none
module low_power_wake_and_host_handshake_test;
	timeunit 1ns;
	timeprecision 1ns;
	// short counts keep the run brief; the receive wake keeps its built-in length
	localparam int SC = 20, DC = 5, WS = 10, WL = 30;
	localparam int RC = lpwk_pkg::RX_WAKE_CYC;
	typedef struct packed {logic proc; logic pin; logic [7:0] c; logic busy; logic lvl;} lpwk_row_s;
	logic clock, rst, rts_n, rx_line, processing, query;
	logic [7:0] cfg;
	logic [3:0] obd;
	logic ign_lvl, alert, abort, lp, off, vsel, busy, pclose, wreset;
	int fails, checks_done, n;
	lpwk_row_s rows[4] = '{'{0, 1, 8'h00, 0, 1}, '{1, 0, 8'h00, 1, 0}, '{0, 0, 8'h80, 0, 0},
		'{1, 1, 8'h04, 1, 1}};
	lpwk_ctrl #(.SLEEP_CYC(SC), .DEB_CYC(DC), .WSHORT_CYC(WS), .WLONG_CYC(WL)) DUT (
		.clock(clock), .rst(rst), .power_config_byte(cfg), .ignition_monitor_input(rts_n), .rx_pin(rx_line),
		.obd_active(obd), .processing(processing), .ignition_level_query(query), .ignition_level(ign_lvl),
		.alert_send(alert), .abort_obd(abort), .low_power(lp), .outputs_off(off), .volt_select(vsel),
		.busy_pin(busy), .protocol_close(pclose), .warm_reset(wreset));
	lpwk_host_model host (.clock(clock), .busy_pin(busy), .rts_n(rts_n), .tx_line(rx_line));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	// count edges until a pulse shows, bounded so a silent design cannot hang
	task automatic wait_for(input int which, input int lim);
		n = 0;
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (n < lim && !(which == 0 ? alert === 1'b1 : which == 1 ? lp === 1'b1 :
			which == 2 ? wreset === 1'b1 : abort === 1'b1));
	endtask : wait_for
	task automatic go_sleep(input logic [7:0] c);
		@(negedge clock);
		cfg = c;
		host.drive_rts(1'b0);
		wait_for(0, 40);
		check(n >= DC && n <= DC + 4, 1);
		wait_for(1, 40);
		check(n >= SC && n <= SC + 2, 1);
	endtask : go_sleep
	task automatic complete_run();
		if (fails == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : complete_run
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// watchdog: one full receive wake pulse, plus 3000 cycles for the rest
	initial begin
		repeat (RC + 3000) @(posedge clock);
		fails++;
		complete_run();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		cfg = 8'h00;
		processing = 1'b0;
		query = 1'b0;
		obd = 4'h0;
		fails = 0;
		checks_done = 0;
		repeat (2) @(posedge clock);
		#1;
		check({busy, lp, ign_lvl}, 3'b101);
		@(negedge clock);
		rst = 1'b0;
		// ordinary cases: busy follows processing, query shows the pin whatever the enables
		foreach (rows[i]) begin
			processing = rows[i].proc;
			cfg = rows[i].c;
			host.drive_rts(rows[i].pin);
			repeat (3) @(negedge clock);
			query = 1'b1;
			@(negedge clock);
			query = 1'b0;
			check(busy, rows[i].busy);
			check(ign_lvl, rows[i].lvl);
		end
		// host interrupts a busy device through the request pin
		processing = 1'b1;
		fork
			host.request();
			begin
				wait_for(3, 10);
				check(n <= 5, 1);
				@(negedge clock);
				processing = 1'b0;
			end
		join
		repeat (5) @(negedge clock);
		check(busy, 1'b0);
		// ignition low without the master enable must be ignored
		cfg = 8'h04;
		host.drive_rts(1'b0);
		wait_for(0, DC + SC + 10);
		check({alert, lp}, 2'b00);
		host.drive_rts(1'b1);
		repeat (DC + 4) @(negedge clock);
		// ignition sleep then ignition wake, long and short delay, enable bit cleared
		for (int k = 1; k >= 0; k--) begin
			go_sleep(k == 1 ? 8'h86 : 8'h84);
			// busy is registered from the sleep flag, so its inversion lands one edge later
			repeat (2) @(negedge clock);
			check({off, vsel, busy}, 3'b101);
			processing = 1'b1;
			repeat (2) @(negedge clock);
			check(busy, 1'b0);
			processing = 1'b0;
			cfg = k == 1 ? 8'h82 : 8'h80;
			host.drive_rts(1'b1);
			wait_for(2, WL + DC + 20);
			check(n >= (k == 1 ? WL : WS) && n <= (k == 1 ? WL : WS) + DC + 8, 1);
			check(pclose, 1'b1);
			@(posedge clock);
			#1;
			check(lp, 1'b0);
		end
		// receive-line wake from a long low pulse
		go_sleep(8'h84);
		host.send_low(RC + 2);
		wait_for(2, WS + 20);
		check(n >= WS - 2 && n <= WS + 4, 1);
		host.drive_rts(1'b1);
		repeat (DC + 4) @(negedge clock);
		// sleep entered with the bus active: no wake until it has gone quiet
		obd = 4'h1;
		go_sleep(8'h84);
		wait_for(2, WS + 20);
		check(lp, 1'b1);
		@(negedge clock);
		obd = 4'h0;
		repeat (3) @(negedge clock);
		obd = 4'h8;
		wait_for(2, WS + 20);
		check(n >= WS && n <= WS + 8, 1);
		host.drive_rts(1'b1);
		obd = 4'h0;
		complete_run();
	end
endmodule : low_power_wake_and_host_handshake_test
`default_nettype wire

// file: verif/lpwk_host_model.sv
`default_nettype none
module lpwk_host_model (
	input wire logic clock, // system clock
	input wire logic busy_pin, // device busy output
	output logic rts_n, // request-to-send, low = request
	output logic tx_line // host transmit, device receive
);
	timeunit 1ns;
	timeprecision 1ns;
	// both lines idle high; request held high while unused
	initial begin
		rts_n = 1'b1;
		tx_line = 1'b1;
	end
	// request pin doubles as the ignition level
	task automatic drive_rts(input logic v);
		@(negedge clock);
		rts_n = v;
	endtask : drive_rts
	// long low on transmit, as a break or slow space would give
	task automatic send_low(input int cyc);
		@(negedge clock);
		tx_line = 1'b0;
		repeat (cyc) @(negedge clock);
		tx_line = 1'b1;
	endtask : send_low
	// sample busy; if high, pull request low until busy falls, bounded
	task automatic request();
		int k;
		k = 0;
		@(negedge clock);
		if (busy_pin) begin
			rts_n = 1'b0;
			while (busy_pin && k < 50) begin
				@(negedge clock);
				k++;
			end
		end
		rts_n = 1'b1;
	endtask : request
endmodule : lpwk_host_model
`default_nettype wire
